// ===== src/plca_map.svh
/*
  Offsets, field positions, reset values and timing counts for the
  phase loss and current limit alarm block.
  Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
*/
`ifndef PLCA_MAP_SVH
`define PLCA_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PLCA_OFS_CTRL 4'h0
`define PLCA_OFS_CFG 4'h4
`define PLCA_OFS_STAT 4'h8
`define PLCA_OFS_IRQ_STAT 4'hc
`define PLCA_OFS_IRQ_CLR 5'h10
`define PLCA_OFS_IRQ_EN 5'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PLCA_CTRL_SRC_LSB 0
`define PLCA_CTRL_SET_LSB 2
`define PLCA_CTRL_CLEN_BIT 4
`define PLCA_CFG_SPL_LSB 0
`define PLCA_CFG_TMO_LSB 4
`define PLCA_CFG_STIME_LSB 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PLCA_SPL_RST 2'h2
`define PLCA_TMO_RST 3'h2
`define PLCA_STIME_RST 8'h0a

// ----------------------------------------------------------------
// timing: tick period and thresholds
// ----------------------------------------------------------------
`define PLCA_CLK_HZ 20000000
`define PLCA_TICK_MS 10
`define PLCA_TICK_CYC (`PLCA_CLK_HZ / 1000 * `PLCA_TICK_MS)
`define PLCA_IGNORE_MS 100
`define PLCA_ALARM_MS 2000
`define PLCA_RAMP_MS 6000
`define PLCA_IGNORE_TK (`PLCA_IGNORE_MS / `PLCA_TICK_MS)
`define PLCA_ALARM_TK (`PLCA_ALARM_MS / `PLCA_TICK_MS)
`define PLCA_RAMP_TK (`PLCA_RAMP_MS / `PLCA_TICK_MS)

`endif

// ===== src/plca_pkg.sv
/*
  Types shared by the phase loss and current limit alarm block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package plca_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_ACCEL = 3'b001,
    ST_RUN = 3'b010,
    ST_DECEL = 3'b011,
    ST_SUSP = 3'b100,
    ST_RAMP = 3'b101
  } plca_mode_t;

  typedef enum logic [1:0]
  {
    SRC_PANEL = 2'b00,
    SRC_REMOTE = 2'b01,
    SRC_SERIAL = 2'b10
  } plca_src_t;

  typedef enum logic [2:0]
  {
    ACT_OFF = 3'b000,
    ACT_WARN = 3'b001,
    ACT_COAST = 3'b010,
    ACT_STOP = 3'b011,
    ACT_BRAKE = 3'b100
  } plca_act_t;

endpackage

// ===== src/plca_tick.sv
/*
  Tick divider: one-cycle enable pulse every TICK_CYC clocks.
  Assumes the single system clock and asynchronous active-low reset.
*/
`timescale 1ns/10ps
`include "plca_map.svh"

module plca_tick
#(
  parameter int TICK_CYC = `PLCA_TICK_CYC
)
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // tick
  output logic tick
);

  typedef struct packed
  {
    logic [17:0] cnt;
    logic tk;
  } plca_tick_st_t;

  plca_tick_st_t s_r;
  plca_tick_st_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tk = 1'b0;
    if (s_r.cnt == 18'(TICK_CYC - 1))
    begin
      s_nxt.cnt = 18'h0;
      s_nxt.tk = 1'b1;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 18'h1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tk;

endmodule

// ===== src/plca_top.sv
/*
  Phase loss and current limit start-timeout protection for a soft
  starter, with an Avalon-MM register slave and one level interrupt.
  Assumes phase status, current-limit status and command inputs are
  synchronous to SYS_CLK (20 MHz) and free of glitches.
*/
// Notes on behaviour
// - during acceleration or deceleration a single phase loss is handled as a multi-phase loss.
// - during full-voltage running a single phase loss acts per setting, 1 warning, 2 coast, default 2.
// - a single phase loss persisting in full-voltage running raises the alarm 2 s after onset, then acts.
// - that alarm stays while the failure lasts and clears once it is gone.
// - a new start command clears a latched phase-loss alarm.
// - start commands are taken only from the source the control-source setting selects.
// - a panel alarm reset is always taken whatever the control source.
// - a panel alarm reset clears alarms only and never starts the motor.
// - with current limit enabled, still limiting when the start time elapses raises the start-timeout alarm unless the timeout action is off.
// - a new start command clears a latched start-timeout alarm.
// - timeout action codes are off, 1 warning, 2 coast, 3 stop, 4 brake, default 2.
// - on timeout with warning or off, ramp to full voltage over 6 s and stop regulating current.
// - four configuration sets exist and one is active.
// - phase failures shorter than 100 ms are ignored, except during deceleration.
// - a multi-phase failure over 100 ms suspends output, restarts softly if gone within 2 s, else alarms and stays off; in ST_RAMP the code ignores it.
// - any phase failure during deceleration switches output off at once and the motor coasts.
`timescale 1ns/10ps
`include "plca_map.svh"

module plca_top
  import plca_pkg::*;
#(
  parameter int TICK_CYC = `PLCA_TICK_CYC,
  parameter int IGNORE_TK = `PLCA_IGNORE_TK,
  parameter int ALARM_TK = `PLCA_ALARM_TK,
  parameter int RAMP_TK = `PLCA_RAMP_TK
)
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // avalon-mm slave
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // supply and drive status
  input wire logic [2:0] PHASE_OK,
  input wire logic CUR_LIMIT,
  input wire logic RAMP_DONE,
  input wire logic STOP_CMD,
  // start and reset commands per source
  input wire logic PANEL_START,
  input wire logic REMOTE_START,
  input wire logic SERIAL_START,
  input wire logic PANEL_RESET,
  // drive and alarm outputs
  output logic OUT_ON,
  output logic FULL_RAMP,
  output logic CUR_REG_OFF,
  output logic STOP_RAMP,
  output logic BRAKE,
  output logic PHASE_LOSS_ALARM,
  output logic START_TIMEOUT_ALARM,
  output logic IRQ
);

  typedef struct packed
  {
    plca_mode_t mode;
    logic [1:0] src;
    logic [1:0] set_sel;
    logic [3:0] clen;
    logic [3:0] [1:0] spl;
    logic [3:0] [2:0] tmo;
    logic [3:0] [7:0] stime;
    logic [8:0] fail_cnt;
    logic [11:0] st_cnt;
    logic [9:0] ramp_cnt;
    logic pl_alarm;
    logic pl_hold;
    logic to_alarm;
    logic [1:0] irq_st;
    logic [1:0] irq_en;
    logic ack;
    logic [31:0] rdata;
  } plca_st_t;

  plca_st_t s_r;
  plca_st_t s_nxt;
  logic tick;
  logic fail_any;
  logic fail_multi;
  logic start_cmd;
  logic fail_long;
  logic fail_alarm;
  logic st_done;
  logic [1:0] a;
  logic [1:0] spl_a;
  plca_act_t tmo_a;
  logic ev_pl;
  logic ev_to;
  logic bus_req;

  plca_tick #(.TICK_CYC(TICK_CYC)) u_tick
  (
    .SYS_CLK(SYS_CLK),
    .RSTN(RSTN),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // decode of inputs and active set
  // ----------------------------------------------------------------
  assign fail_any = ~&PHASE_OK;
  assign fail_multi = $countones(PHASE_OK) < 2;
  assign a = s_r.set_sel;
  assign spl_a = s_r.spl[a];
  assign tmo_a = plca_act_t'(s_r.tmo[a]);
  assign fail_long = s_r.fail_cnt >= 9'(IGNORE_TK);
  assign fail_alarm = s_r.fail_cnt >= 9'(ALARM_TK);
  // start time is kept in 100 ms units; 12 bits hold the largest setting
  assign st_done = s_r.st_cnt >=
    12'(s_r.stime[a]) * 12'(100 / `PLCA_TICK_MS);
  assign bus_req = (AVS_READ || AVS_WRITE) && !s_r.ack;

  assign start_cmd = (s_r.src == SRC_PANEL) ? PANEL_START :
    (s_r.src == SRC_REMOTE) ? REMOTE_START :
    (s_r.src == SRC_SERIAL) && SERIAL_START;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    ev_pl = 1'b0;
    ev_to = 1'b0;
    // failure timer in ticks, restarts on any clear
    if (!fail_any)
      s_nxt.fail_cnt = 9'h0;
    else if (tick && !fail_alarm)
      s_nxt.fail_cnt = s_r.fail_cnt + 9'h1;
    // hold ends with the failure so a later loss can alarm again
    s_nxt.pl_hold = s_r.pl_hold && fail_any;
    if (s_r.pl_hold && !fail_any)
      s_nxt.pl_alarm = 1'b0;
    // panel reset clears alarms only, never starts
    if (PANEL_RESET)
    begin
      s_nxt.pl_alarm = 1'b0;
      s_nxt.to_alarm = 1'b0;
    end
    unique case (s_r.mode)
      ST_IDLE:
      begin
        if (start_cmd)
        begin
          s_nxt.pl_alarm = 1'b0;
          s_nxt.to_alarm = 1'b0;
          s_nxt.pl_hold = 1'b0;
          s_nxt.st_cnt = 12'h0;
          s_nxt.mode = ST_ACCEL;
        end
      end
      ST_ACCEL:
      begin
        if (tick && s_r.st_cnt != 12'hfff)
          s_nxt.st_cnt = s_r.st_cnt + 12'h1;
        if (STOP_CMD)
          s_nxt.mode = ST_DECEL;
        else if (fail_any && fail_long)
          s_nxt.mode = ST_SUSP;
        else if (s_r.clen[a] && CUR_LIMIT && st_done)
        begin
          if (tmo_a != ACT_OFF)
          begin
            ev_to = 1'b1;
            s_nxt.to_alarm = 1'b1;
          end
          if (tmo_a == ACT_WARN || tmo_a == ACT_OFF)
          begin
            s_nxt.ramp_cnt = 10'h0;
            s_nxt.mode = ST_RAMP;
          end
          else
            s_nxt.mode = ST_IDLE;
        end
        else if (RAMP_DONE)
          s_nxt.mode = ST_RUN;
      end
      ST_RAMP:
      begin
        if (tick)
          s_nxt.ramp_cnt = s_r.ramp_cnt + 10'h1;
        if (s_r.ramp_cnt >= 10'(RAMP_TK))
          s_nxt.mode = ST_RUN;
      end
      ST_RUN:
      begin
        if (STOP_CMD)
          s_nxt.mode = ST_DECEL;
        else if (fail_multi && fail_long)
          s_nxt.mode = ST_SUSP;
        else if (fail_any && fail_alarm && !s_r.pl_hold)
        begin
          ev_pl = 1'b1;
          s_nxt.pl_alarm = 1'b1;
          s_nxt.pl_hold = 1'b1;
          if (spl_a != 2'h1)
            s_nxt.mode = ST_IDLE;
        end
      end
      ST_DECEL:
      begin
        if (fail_any || RAMP_DONE)
          s_nxt.mode = ST_IDLE;
      end
      ST_SUSP:
      begin
        if (!fail_any)
        begin
          s_nxt.st_cnt = 12'h0;
          s_nxt.mode = ST_ACCEL;
        end
        else if (fail_alarm)
        begin
          ev_pl = 1'b1;
          s_nxt.pl_alarm = 1'b1;
          s_nxt.mode = ST_IDLE;
        end
      end
      default: s_nxt.mode = ST_IDLE;
    endcase
    // ----------------------------------------------------------------
    // register slave: one wait cycle, then ack
    // ----------------------------------------------------------------
    s_nxt.ack = bus_req;
    if (AVS_WRITE && bus_req)
    begin
      unique case (AVS_ADDRESS)
        5'(`PLCA_OFS_CTRL):
        begin
          s_nxt.src = AVS_WRITEDATA[`PLCA_CTRL_SRC_LSB +: 2];
          s_nxt.set_sel = AVS_WRITEDATA[`PLCA_CTRL_SET_LSB +: 2];
          s_nxt.clen[AVS_WRITEDATA[`PLCA_CTRL_SET_LSB +: 2]] =
            AVS_WRITEDATA[`PLCA_CTRL_CLEN_BIT];
        end
        5'(`PLCA_OFS_CFG):
        begin
          if (AVS_WRITEDATA[`PLCA_CFG_SPL_LSB +: 2] != 2'h0)
            s_nxt.spl[a] = AVS_WRITEDATA[`PLCA_CFG_SPL_LSB +: 2];
          if (AVS_WRITEDATA[`PLCA_CFG_TMO_LSB +: 3] <= 3'h4)
            s_nxt.tmo[a] = AVS_WRITEDATA[`PLCA_CFG_TMO_LSB +: 3];
          s_nxt.stime[a] = AVS_WRITEDATA[`PLCA_CFG_STIME_LSB +: 8];
        end
        5'(`PLCA_OFS_IRQ_CLR): s_nxt.irq_st = s_r.irq_st &
          ~AVS_WRITEDATA[1:0];
        5'(`PLCA_OFS_IRQ_EN): s_nxt.irq_en = AVS_WRITEDATA[1:0];
        default: ;
      endcase
    end
    // set beats clear in the same cycle
    s_nxt.irq_st = s_nxt.irq_st | {ev_to, ev_pl};
    s_nxt.rdata = 32'h0;
    if (AVS_READ && bus_req)
    begin
      unique case (AVS_ADDRESS)
        5'(`PLCA_OFS_CTRL): s_nxt.rdata = {27'h0, s_r.clen[a],
          s_r.set_sel, s_r.src};
        5'(`PLCA_OFS_CFG): s_nxt.rdata = {16'h0, s_r.stime[a], 1'b0,
          s_r.tmo[a], 2'h0, s_r.spl[a]};
        5'(`PLCA_OFS_STAT): s_nxt.rdata = {24'h0, fail_any, s_r.mode,
          2'h0, s_r.to_alarm, s_r.pl_alarm};
        5'(`PLCA_OFS_IRQ_STAT): s_nxt.rdata = {30'h0, s_r.irq_st};
        5'(`PLCA_OFS_IRQ_EN): s_nxt.rdata = {30'h0, s_r.irq_en};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      s_r <= '0;
      s_r.spl <= {4{`PLCA_SPL_RST}};
      s_r.tmo <= {4{`PLCA_TMO_RST}};
      s_r.stime <= {4{`PLCA_STIME_RST}};
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !s_r.ack;
  assign AVS_READDATA = s_r.rdata;
  assign OUT_ON = (s_r.mode == ST_ACCEL) || (s_r.mode == ST_RUN) ||
    (s_r.mode == ST_DECEL) || (s_r.mode == ST_RAMP);
  assign FULL_RAMP = s_r.mode == ST_RAMP;
  assign CUR_REG_OFF = FULL_RAMP;
  assign STOP_RAMP = s_r.to_alarm && tmo_a == ACT_STOP &&
    s_r.mode == ST_IDLE;
  assign BRAKE = s_r.to_alarm && tmo_a == ACT_BRAKE &&
    s_r.mode == ST_IDLE;
  assign PHASE_LOSS_ALARM = s_r.pl_alarm;
  assign START_TIMEOUT_ALARM = s_r.to_alarm;
  assign IRQ = |(s_r.irq_st & s_r.irq_en);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  short_fail_ignored_a: assert property (@(posedge SYS_CLK) disable iff
    (!RSTN) (s_r.mode == ST_RUN && !fail_long) |=> s_r.mode != ST_SUSP)
    else $error("short failure acted on");
  decel_cut_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (s_r.mode == ST_DECEL && fail_any) |=> !OUT_ON)
    else $error("output left on in deceleration");
  alarm_clears_a: assert property (@(posedge SYS_CLK) disable iff
    (!RSTN) (s_r.pl_hold && !fail_any) |=> !s_r.pl_alarm)
    else $error("phase alarm held after failure gone");
  start_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (s_r.mode == ST_IDLE && start_cmd) |=> !s_r.pl_alarm && !s_r.to_alarm)
    else $error("start did not clear alarms");
  panel_no_start_a: assert property (@(posedge SYS_CLK) disable iff
    (!RSTN) (s_r.mode == ST_IDLE && !start_cmd) |=> s_r.mode == ST_IDLE)
    else $error("motor started without start");
  event_latch_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    ev_to |=> s_r.irq_st[1])
    else $error("timeout event not latched");
  warn_keeps_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (ev_pl && s_r.mode == ST_RUN && spl_a == 2'h1) |=> s_r.mode == ST_RUN)
    else $error("warning stopped the motor");
  ramp_len_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(FULL_RAMP) |=> FULL_RAMP [*8])
    else $error("full ramp ended early");

endmodule

// ===== testbench/plca_cmd_model.sv
/*
  Command source model: panel, remote and serial start pulses and the
  panel alarm reset. Callers enter press just after a rising edge.
*/
`timescale 1ns/10ps

module plca_cmd_model
(
  // clock
  input wire logic SYS_CLK,
  // commands
  output logic PANEL_START,
  output logic REMOTE_START,
  output logic SERIAL_START,
  output logic PANEL_RESET
);
  logic [3:0] cmd_r = 4'h0;

  assign {PANEL_RESET, SERIAL_START, REMOTE_START, PANEL_START} = cmd_r;

  // ----------------------------------------------------------------
  // one-cycle pulse, then a quiet cycle before the next request
  // ----------------------------------------------------------------
  task press(input int which);
    cmd_r <= 4'h1 << which;
    @(posedge SYS_CLK);
    cmd_r <= 4'h0;
    @(posedge SYS_CLK);
  endtask
endmodule

// ===== testbench/plca_top_bench.sv
/*
  Self-checking bench for the phase loss and start-timeout block.
  Assumes short tick and threshold parameters and one bus wait cycle.
*/
`timescale 1ns/10ps
`include "plca_map.svh"

module plca_top_bench;
  import plca_pkg::*;
  localparam logic [4:0] A_CTRL = 5'(`PLCA_OFS_CTRL);
  localparam logic [4:0] A_CFG = 5'(`PLCA_OFS_CFG);
  localparam logic [4:0] A_STAT = 5'(`PLCA_OFS_STAT);
  localparam logic [4:0] A_IST = 5'(`PLCA_OFS_IRQ_STAT);
  localparam logic [4:0] A_ICLR = 5'(`PLCA_OFS_IRQ_CLR);
  localparam logic [4:0] A_IEN = 5'(`PLCA_OFS_IRQ_EN);
  logic clk, rstn, rd, wr, cl, rdone, stop;
  logic [4:0] adr;
  logic [31:0] wd;
  logic [2:0] ph;
  logic [31:0] rdata, q, rd_s, outs_s;
  logic wreq, ps, rs, ss, pr, out_on, fr, cro, sr, brk, pla, sta, irq;
  logic wq_s = 1'b1;
  logic [31:0] om [5] = '{32'h2, 32'h2, 32'h1, 32'h8, 32'h10};
  logic [31:0] oe [5] = '{32'h2, 32'h2, 32'h0, 32'h8, 32'h10};
  int n_fail = 0;
  int tests_run = 0;

  plca_top #(.TICK_CYC(4), .IGNORE_TK(2), .ALARM_TK(6), .RAMP_TK(10)) u_dut
  (
    .SYS_CLK(clk), .RSTN(rstn), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .PHASE_OK(ph), .CUR_LIMIT(cl),
    .RAMP_DONE(rdone), .STOP_CMD(stop), .PANEL_START(ps),
    .REMOTE_START(rs), .SERIAL_START(ss), .PANEL_RESET(pr),
    .OUT_ON(out_on), .FULL_RAMP(fr), .CUR_REG_OFF(cro), .STOP_RAMP(sr),
    .BRAKE(brk), .PHASE_LOSS_ALARM(pla), .START_TIMEOUT_ALARM(sta),
    .IRQ(irq)
  );

  plca_cmd_model u_cmd
  (
    .SYS_CLK(clk), .PANEL_START(ps), .REMOTE_START(rs),
    .SERIAL_START(ss), .PANEL_RESET(pr)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // values settled before each rising edge, free of edge races
  // ----------------------------------------------------------------
  always @(negedge clk)
  begin
    wq_s <= wreq;
    rd_s <= rdata;
    outs_s <= {24'h0, sta, pla, irq, brk, sr, cro, fr, out_on};
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] md(input plca_mode_t m);
    return {25'h0, m, 4'h0};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    i = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (wq_s && i < 50);
    if (wq_s) chk(32'h1, 32'h0);
    q = rd_s;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task rreg(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  // bounded wait on a register field by repeated reads
  task poll(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    int i;
    i = 0;
    bus(1'b0, a, 32'h0);
    while ((q & m) !== e && i < 200)
    begin
      bus(1'b0, a, 32'h0);
      i++;
    end
    chk(q & m, e);
  endtask

  task wait_out(input logic [31:0] m, input logic [31:0] e, input int lim);
    int i;
    i = 0;
    while ((outs_s & m) !== e && i < lim)
    begin
      @(posedge clk);
      i++;
    end
    chk(outs_s & m, e);
  endtask

  task to_idle();
    stop <= 1'b1;
    rdone <= 1'b1;
    poll(A_STAT, 32'h70, md(ST_IDLE));
    stop <= 1'b0;
    rdone <= 1'b0;
  endtask

  task test_done();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    rstn <= 1'b0;
    {adr, rd, wr, wd, cl, rdone, stop} <= '0;
    ph <= 3'h7;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rreg(A_CFG, 32'hff77, 32'h0a22);
    rreg(A_CTRL, 32'hf, 32'h0);
    rreg(A_STAT, 32'h73, 32'h0);
    bus(1'b1, 5'h18, 32'hffff);
    rreg(5'h18, 32'hffffffff, 32'h0);
    bus(1'b1, A_CTRL, 32'h4);
    bus(1'b1, A_CFG, 32'h0131);
    bus(1'b1, A_CTRL, 32'h10);
    rreg(A_CFG, 32'hff77, 32'h0a22);
    bus(1'b1, A_CTRL, 32'h14);
    rreg(A_CFG, 32'hff77, 32'h0131);
    bus(1'b1, A_CTRL, 32'h10);
    bus(1'b1, A_CFG, 32'h0222);
    $display("registers done");
    u_cmd.press(0);
    poll(A_STAT, 32'h70, md(ST_ACCEL));
    ph <= 3'b110;
    poll(A_STAT, 32'h70, md(ST_SUSP));
    wait_out(32'h1, 32'h0, 3);
    ph <= 3'h7;
    poll(A_STAT, 32'h70, md(ST_ACCEL));
    rdone <= 1'b1;
    poll(A_STAT, 32'h70, md(ST_RUN));
    ph <= 3'b011;
    repeat (3) @(posedge clk);
    ph <= 3'h7;
    repeat (30) @(posedge clk);
    rreg(A_STAT, 32'h73, md(ST_RUN));
    ph <= 3'b101;
    repeat (12) @(posedge clk);
    rreg(A_STAT, 32'h1, 32'h0);
    poll(A_STAT, 32'h1, 32'h1);
    wait_out(32'h40, 32'h40, 3);
    rreg(A_IST, 32'h1, 32'h1);
    wait_out(32'h1, 32'h0, 3);
    repeat (40) @(posedge clk);
    rreg(A_STAT, 32'h1, 32'h1);
    ph <= 3'h7;
    poll(A_STAT, 32'h1, 32'h0);
    bus(1'b1, A_CFG, 32'h0221);
    u_cmd.press(0);
    poll(A_STAT, 32'h70, md(ST_RUN));
    ph <= 3'b110;
    poll(A_STAT, 32'h1, 32'h1);
    rreg(A_STAT, 32'h70, md(ST_RUN));
    chk(outs_s & 32'h1, 32'h1);
    ph <= 3'h7;
    stop <= 1'b1;
    rdone <= 1'b0;
    poll(A_STAT, 32'h70, md(ST_DECEL));
    ph <= 3'b110;
    wait_out(32'h1, 32'h0, 3);
    ph <= 3'h7;
    to_idle();
    bus(1'b1, A_CFG, 32'h0222);
    u_cmd.press(0);
    rdone <= 1'b1;
    poll(A_STAT, 32'h70, md(ST_RUN));
    ph <= 3'b001;
    poll(A_STAT, 32'h1, 32'h1);
    wait_out(32'h1, 32'h0, 3);
    ph <= 3'h7;
    u_cmd.press(0);
    poll(A_STAT, 32'h1, 32'h0);
    to_idle();
    $display("phase loss done");
    cl <= 1'b1;
    for (int c = 0; c < 5; c++)
    begin
      bus(1'b1, A_CFG, 32'h0202 | (32'(c) << 4));
      u_cmd.press(0);
      poll(A_STAT, 32'h2, 32'h0);
      if (c != 0) poll(A_STAT, 32'h2, 32'h2);
      wait_out(om[c], oe[c], 400);
      if (c < 2) wait_out(32'h4, 32'h4, 200);
      if (c < 2)
      begin
        // ramp lasts ten ticks of four cycles, poll lag included
        repeat (32) @(posedge clk);
        chk(outs_s & 32'h2, 32'h2);
        wait_out(32'h2, 32'h0, 12);
      end
      if (c == 0) rreg(A_STAT, 32'h2, 32'h0);
      to_idle();
    end
    $display("start timeout done");
    bus(1'b1, A_CFG, 32'h0222);
    bus(1'b1, A_CTRL, 32'h11);
    bus(1'b1, A_ICLR, 32'h3);
    rreg(A_IST, 32'h3, 32'h0);
    bus(1'b1, A_IEN, 32'h2);
    for (int s = 0; s < 3; s += 2)
    begin
      u_cmd.press(s);
      repeat (10) @(posedge clk);
      rreg(A_STAT, 32'h70, md(ST_IDLE));
    end
    u_cmd.press(1);
    poll(A_STAT, 32'h2, 32'h2);
    wait_out(32'h80, 32'h80, 3);
    wait_out(32'h20, 32'h20, 5);
    rreg(A_IST, 32'h3, 32'h2);
    bus(1'b1, A_IEN, 32'h0);
    wait_out(32'h20, 32'h0, 5);
    bus(1'b1, A_IEN, 32'h2);
    wait_out(32'h20, 32'h20, 5);
    bus(1'b1, A_ICLR, 32'h2);
    wait_out(32'h20, 32'h0, 5);
    rreg(A_IST, 32'h3, 32'h0);
    u_cmd.press(3);
    poll(A_STAT, 32'h2, 32'h0);
    wait_out(32'hc0, 32'h0, 3);
    repeat (20) @(posedge clk);
    rreg(A_STAT, 32'h70, md(ST_IDLE));
    chk(outs_s & 32'h1, 32'h0);
    // serial source, current limit check switched off for set 0
    bus(1'b1, A_CTRL, 32'h2);
    u_cmd.press(2);
    poll(A_STAT, 32'h70, md(ST_ACCEL));
    repeat (100) @(posedge clk);
    rreg(A_STAT, 32'h72, md(ST_ACCEL));
    to_idle();
    $display("sources and interrupt done");
    test_done();
  end
endmodule
